/* File: include/swi_host_regs.vh */
// constants for the single-wire identity bus master: timing, opcodes, flags
// assumes a 10 MHz system clock; all line timing is counted in 1 us ticks
`ifndef SWI_HOST_REGS_VH
`define SWI_HOST_REGS_VH

// clock rate and the 1 us tick divider
`define SWI_CLK_HZ            10000000
`define SWI_HZ_PER_US         1000000
`define SWI_TICK_CYCLES       (`SWI_CLK_HZ / `SWI_HZ_PER_US)

// line timing, microseconds
`define SWI_RESET_LOW_US      10'd480
`define SWI_RESET_HIGH_US     10'd480
`define SWI_PRESENCE_SMPL_US  10'd70
`define SWI_WRITE_ONE_LOW_US  10'd2
`define SWI_WRITE_ZERO_LOW_US 10'd60
`define SWI_READ_SMPL_US      10'd13
`define SWI_SLOT_LENGTH_US    10'd70

// user command opcodes
`define SWI_OP_RESET          2'h0
`define SWI_OP_WRITE          2'h1
`define SWI_OP_READ           2'h2
`define SWI_OP_TRIPLET        2'h3

// identity command bytes sent with the write opcode
`define SWI_CMD_READ_ID       8'h33
`define SWI_CMD_READ_ID_ALT   8'h0F
`define SWI_CMD_MATCH         8'h55
`define SWI_CMD_SKIP          8'hCC
`define SWI_CMD_SEARCH        8'hF0

// check code, x^8 + x^5 + x^4 + 1 in shift-right form
`define SWI_CRC_POLY          8'h8C
`define SWI_CRC_INIT          8'h00

// response flag bit positions
`define SWI_FLG_PRESENCE      0
`define SWI_FLG_CRC_OK        1
`define SWI_FLG_ID_BIT        2
`define SWI_FLG_CMP_BIT       3
`define SWI_FLG_DIR           4
`define SWI_FLG_NO_DEVICE     5

// response buffer shape
`define SWI_RSP_WIDTH         16
`define SWI_RSP_ADDR_BITS     1

`endif

/* File: src/swi_buf2.v */
// two-entry valid/ready buffer for response words
// assumes producer and consumer share clk; synchronous active-high reset
`timescale 1ns/1ns
module swi_buf2
#(
  parameter WIDTH = 16,
  parameter AW    = 1
)
(
  input  wire             clk,
  input  wire             reset,
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);

  // constants sized to the counters so nothing is cut silently
  localparam [AW:0] FULL = {1'b1, {AW{1'b0}}};
  localparam [AW:0] STEP = {{AW{1'b0}}, 1'b1};

  reg [WIDTH-1:0] mem [0:(1<<AW)-1];
  reg [AW-1:0]    wr_ptr;
  reg [AW-1:0]    rd_ptr;
  reg [AW:0]      count;

  wire            push;
  wire            pop;

  // full is honest, so a stalled reader really stops the writer
  assign in_ready  = (count != FULL);
  assign out_valid = (count != {(AW+1){1'b0}});
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // storage is written only on an accepted push
  always @(posedge clk)
  begin
    if (push)
      mem[wr_ptr] <= in_data;
  end

  // pointers and occupancy
  always @(posedge clk)
  begin
    if (reset)
    begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count  <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
        wr_ptr <= wr_ptr + STEP[AW-1:0];
      if (pop)
        rd_ptr <= rd_ptr + STEP[AW-1:0];
      if (push && !pop)
        count <= count + STEP;
      else if (pop && !push)
        count <= count - STEP;
    end
  end

endmodule

/* File: src/swi_host.v */
// bus master for a single-wire open-drain identity ROM bus
// assumes an external pull-up on the line and a 10 MHz clk; the pin
// reaches this block as line_in (async) and is driven via line_oe only
// limitation: standard speed only; no strong pull-up for powered slaves
//
// Contract
// - all bits on the line travel least significant bit first
// - master checks received bytes with x^8+x^5+x^4+1 against the last byte
// - line idles high; master releases it whenever a transaction pauses
// - every transaction starts with master reset then slave presence pulse
// - access order: initialization, one command byte, then data transfer
// - each command is one 8-bit byte sent after presence is seen
// - master reads identity only when one slave is attached
// - search: slave sends bit, then complement, then samples master's bit
// - reset pulse: master holds line low at least 480 us, then releases
// - master waits at least 480 us high after reset before anything else
// - only presence is slave-started; all other slots master-started
// - each slot starts with master pulling low; slaves time from that edge
// - master samples read slot late but within 15 us of falling edge
// - reset low plus recovery stays under 960 us; here the two come to exactly 960 us
// - bus data rate stays at or below 16.3 kbit/s
`timescale 1ns/1ns
`include "swi_host_regs.vh"
module swi_host
(
  input  wire        clk,
  input  wire        reset,
  input  wire        cmd_valid,
  output wire        cmd_ready,
  input  wire [1:0]  cmd_op,
  input  wire [7:0]  cmd_data,
  input  wire        cmd_dir,
  output wire        rsp_valid,
  input  wire        rsp_ready,
  output wire [7:0]  rsp_data,
  output wire [7:0]  rsp_flags,
  input  wire        line_in,
  output wire        line_out,
  output wire        line_oe,
  output wire        busy
);

  // one-hot states
  localparam [4:0] S_IDLE  = 5'h01;
  localparam [4:0] S_RLOW  = 5'h02;
  localparam [4:0] S_RWAIT = 5'h04;
  localparam [4:0] S_SLOT  = 5'h08;
  localparam [4:0] S_PUSH  = 5'h10;

  // divider terminal count, cut to the divider's width on purpose
  localparam integer TICK_CYC  = `SWI_TICK_CYCLES - 1;
  localparam [3:0]   TICK_LAST = TICK_CYC[3:0];

  // sequencer, divider and shift path state
  reg  [4:0]  state;
  reg  [3:0]  div;
  reg  [9:0]  us_cnt;
  reg         line_s1;
  reg         line_s2;
  reg         drive_low;
  reg  [1:0]  op;
  reg         dir_req;
  reg  [7:0]  shreg;
  reg  [2:0]  slot_cnt;
  reg         sample;
  reg  [7:0]  crc;
  reg         presence;
  reg         id_bit;
  reg         cmp_bit;
  reg         dir_taken;
  reg         no_device;

  // combinational helpers and the buffer handshake
  wire        tick;
  wire [9:0]  low_len;
  wire        last_slot;
  wire        crc_fb;
  wire [7:0]  crc_next;
  wire        choose;
  wire        buf_in_ready;
  wire        buf_in_valid;
  wire [7:0]  flags_word;
  wire [15:0] buf_in_data;
  wire [15:0] buf_out_data;

  // pin synchroniser: only line_s2 is read by logic
  always @(posedge clk)
  begin
    if (reset)
    begin
      line_s1 <= 1'b1;
      line_s2 <= 1'b1;
    end
    else
    begin
      line_s1 <= line_in;
      line_s2 <= line_s1;
    end
  end

  // 1 us enable; restarted at every phase so each edge lands on a whole us
  assign tick = (div == TICK_LAST);

  // low time of the current slot; reads use the short write-one pulse
  assign low_len   = shreg[0] ? `SWI_WRITE_ONE_LOW_US : `SWI_WRITE_ZERO_LOW_US;
  assign last_slot = (op == `SWI_OP_TRIPLET) ? (slot_cnt == 3'h2) : (slot_cnt == 3'h7);

  // running check code over every bit of a read command since the last reset
  assign crc_fb   = crc[0] ^ sample;
  assign crc_next = {1'b0, crc[7:1]} ^ (crc_fb ? `SWI_CRC_POLY : 8'h00);

  // search direction: follow the only bit present, else the caller's choice
  assign choose = (id_bit ^ sample) ? id_bit : dir_req;

  // line pin: open drain, the output value is always low
  assign line_out = 1'b0;
  assign line_oe  = drive_low;

  // new commands wait for a high line and room for the answer
  assign cmd_ready = (state == S_IDLE) & buf_in_ready & line_s2;
  assign busy      = (state != S_IDLE);

  // main sequencer
  always @(posedge clk)
  begin
    if (reset)
    begin
      state     <= S_IDLE;
      div       <= 4'h0;
      us_cnt    <= 10'h000;
      drive_low <= 1'b0;
      op        <= `SWI_OP_RESET;
      dir_req   <= 1'b0;
      shreg     <= 8'h00;
      slot_cnt  <= 3'h0;
      sample    <= 1'b1;
      crc       <= `SWI_CRC_INIT;
      presence  <= 1'b0;
      id_bit    <= 1'b0;
      cmp_bit   <= 1'b0;
      dir_taken <= 1'b0;
      no_device <= 1'b0;
    end
    else
    begin
      div <= tick ? 4'h0 : div + 4'h1;
      if (tick)
        us_cnt <= us_cnt + 10'h001;
      case (state)
        S_IDLE:
        begin
          if (cmd_valid && cmd_ready)
          begin
            op        <= cmd_op;
            dir_req   <= cmd_dir;
            div       <= 4'h0;
            us_cnt    <= 10'h000;
            slot_cnt  <= 3'h0;
            drive_low <= 1'b1;
            // search flags start clean so no stale result is reported
            id_bit    <= 1'b0;
            cmp_bit   <= 1'b0;
            dir_taken <= 1'b0;
            no_device <= 1'b0;
            if (cmd_op == `SWI_OP_RESET)
            begin
              // a reset opens a new transaction and a new check code
              state    <= S_RLOW;
              presence <= 1'b0;
              crc      <= `SWI_CRC_INIT;
            end
            else
            begin
              // writes send cmd_data; reads and search start with all ones
              state <= S_SLOT;
              // all ones keep the line released so the slave alone sets each bit
              shreg <= (cmd_op == `SWI_OP_WRITE) ? cmd_data : 8'hFF;
            end
          end
        end
        S_RLOW:
        begin
          // hold low for the reset time, then release and listen
          // exactly the minimum, so reset plus recovery comes to exactly 960 us
          if (tick && us_cnt == `SWI_RESET_LOW_US - 10'h001)
          begin
            drive_low <= 1'b0;
            state     <= S_RWAIT;
            us_cnt    <= 10'h000;
            div       <= 4'h0;
          end
        end
        S_RWAIT:
        begin
          // a missing pulse is reported in the flags, not retried here
          // 70 us after release sits inside every legal presence pulse
          if (tick && us_cnt == `SWI_PRESENCE_SMPL_US - 10'h001)
            presence <= ~line_s2;
          // nothing new starts before the full high time is spent
          if (tick && us_cnt == `SWI_RESET_HIGH_US - 10'h001)
            state <= S_PUSH;
        end
        S_SLOT:
        begin
          // end of the low part of the slot
          if (tick && us_cnt == low_len - 10'h001)
            drive_low <= 1'b0;
          // read point just before the slave's valid window closes
          if (tick && us_cnt == `SWI_READ_SMPL_US - 10'h001)
            // two slaves answering at once show up here as their wired AND
            sample <= line_s2;
          // slot end leaves recovery time before the next falling edge
          if (tick && us_cnt == `SWI_SLOT_LENGTH_US - 10'h001)
          begin
            slot_cnt <= slot_cnt + 3'h1;
            shreg    <= {sample, shreg[7:1]};
            if (op == `SWI_OP_READ)
              crc <= crc_next;
            if (op == `SWI_OP_TRIPLET && slot_cnt == 3'h0)
              id_bit <= sample;
            if (op == `SWI_OP_TRIPLET && slot_cnt == 3'h1)
            begin
              cmp_bit   <= sample;
              dir_taken <= choose;
              // both ones: no slave is still taking part
              no_device <= id_bit & sample;
              shreg[0]  <= choose;
            end
            // both bits high: nobody is left to take the write slot
            if (last_slot || (op == `SWI_OP_TRIPLET && slot_cnt == 3'h1 && id_bit && sample))
            begin
              state <= S_PUSH;
            end
            else
            begin
              us_cnt    <= 10'h000;
              div       <= 4'h0;
              drive_low <= 1'b1;
            end
          end
        end
        S_PUSH:
        begin
          // answer waits here while the buffer is full
          // cmd_ready already checked for room, so this wait is only a guard
          if (buf_in_ready)
            state <= S_IDLE;
        end
        default:
        begin
          state     <= S_IDLE;
          drive_low <= 1'b0;
        end
      endcase
    end
  end

  // response word: flags in the high byte, data in the low byte
  // crc_ok only means something after the last byte of an identity
  assign flags_word[`SWI_FLG_PRESENCE]  = presence;
  assign flags_word[`SWI_FLG_CRC_OK]    = (crc == 8'h00);
  assign flags_word[`SWI_FLG_ID_BIT]    = id_bit;
  assign flags_word[`SWI_FLG_CMP_BIT]   = cmp_bit;
  assign flags_word[`SWI_FLG_DIR]       = dir_taken;
  assign flags_word[`SWI_FLG_NO_DEVICE] = no_device | ((op == `SWI_OP_RESET) & ~presence);
  assign flags_word[7:6]                = 2'h0;

  assign buf_in_valid = (state == S_PUSH);
  assign buf_in_data  = {flags_word, (op == `SWI_OP_TRIPLET) ? 8'h00 : shreg};

  // results queue so a slow reader never loses one
  swi_buf2
  #(
    .WIDTH (`SWI_RSP_WIDTH),
    .AW    (`SWI_RSP_ADDR_BITS)
  )
  u_rsp_buf
  (
    .clk       (clk),
    .reset     (reset),
    .in_valid  (buf_in_valid),
    .in_ready  (buf_in_ready),
    .in_data   (buf_in_data),
    .out_valid (rsp_valid),
    .out_ready (rsp_ready),
    .out_data  (buf_out_data)
  );

  // the buffer word splits back into data and flags
  assign rsp_data  = buf_out_data[7:0];
  assign rsp_flags = buf_out_data[15:8];

endmodule

/* File: tb/swi_dev_model.sv */
// behavioural identity device on the single-wire line
// assumes 1 ns units; it only pulls low, the bench adds the pull-up
`timescale 1ns/1ns
module swi_dev_model
#(
  parameter [63:0] ID = 64'h0
)
(
  input  wire line,
  output reg  pull
);
  integer   st; // 0 silent, 1 command, 2 read, 3 search
  integer   n;
  integer   ph;
  reg [7:0] cmd;
  reg       b;
  time      tfall;
  initial
  begin
    pull = 1'b0;
    st = 0;
    n = 0;
    ph = 0;
    tfall = 0;
  end
  // slots time from the master's fall; a read bit holds only 15 us
  always @(negedge line)
    if (!pull)
    begin
      tfall = $time;
      if (st == 2 || (st == 3 && ph < 2))
      begin
        b = (st == 3 && ph == 1) ? ~ID[n] : ID[n];
        if (st == 3)
          ph = ph + 1;
        else
          n = n + 1;
        if (st == 2 && n == 64)
          st = 0;
        if (!b)
        begin
          pull = 1'b1;
          #15000;
          pull = 1'b0;
        end
      end
      else
      begin
        #30000;
        b = line;
        if (st == 1)
        begin
          cmd[n] = b;
          n = n + 1;
          if (n == 8)
            st = (cmd == 8'h33 || cmd == 8'h0F) ? 2 : ((cmd == 8'hF0) ? 3 : 0);
          if (n == 8)
            n = 0;
        end
        else if (st == 3)
        begin
          ph = 0;
          n = n + 1;
          if (b != ID[n-1] || n == 64)
            st = 0;
        end
      end
    end
  // a long low abandons all; presence follows the rise
  always @(posedge line)
    if ($time - tfall > 120000)
    begin
      st = 0;
      #30000;
      pull = 1'b1;
      #120000;
      pull = 1'b0;
      tfall = $time;
      n = 0;
      ph = 0;
      st = 1;
    end
endmodule

/* File: tb/swi_host_sva.sv */
// checker for swi_host: slot timing, spans, command gating
// assumes a 10 MHz clk; bound to every swi_host
`timescale 1ns/1ns
module swi_host_sva
(
  input wire       clk,
  input wire       reset,
  input wire       cmd_valid,
  input wire       cmd_ready,
  input wire [1:0] cmd_op,
  input wire [7:0] cmd_data,
  input wire       cmd_dir,
  input wire       rsp_valid,
  input wire       rsp_ready,
  input wire [7:0] rsp_data,
  input wire [7:0] rsp_flags,
  input wire       line_in,
  input wire       line_out,
  input wire       line_oe,
  input wire       busy
);
  reg  [13:0] orun;
  reg  [13:0] gap;
  reg  [13:0] blen;
  reg  [1:0]  lop;
  wire        take;
  assign take = cmd_valid && cmd_ready;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // low run, cycles since slot start, busy span, op in flight
  always @(posedge clk)
    if (reset)
    begin
      orun <= 14'h0000;
      gap  <= 14'h0000;
      blen <= 14'h0000;
      lop  <= 2'h0;
    end
    else
    begin
      orun <= line_oe ? orun + 14'h0001 : 14'h0000;
      gap  <= $rose(line_oe) ? 14'h0001 : gap + {13'h0000, ~&gap}; // saturates
      blen <= busy ? blen + 14'h0001 : 14'h0000;
      lop  <= take ? cmd_op : lop;
    end
  a_pull_only: assert property (line_out == 1'b0)
    else $error("line driven high");
  a_take_pulls: assert property (take |=> busy && line_oe)
    else $error("no slot after take");
  a_ready_gate: assert property (cmd_ready |-> !busy && !line_oe && $past(line_in, 2))
    else $error("ready while busy or line low");
  a_reset_low: assert property ($fell(line_oe) && lop == 2'h0 |-> orun == 14'h12C0)
    else $error("reset pulse length");
  a_slot_low: assert property ($fell(line_oe) && lop != 2'h0 |-> orun == 14'h014 || orun == 14'h258)
    else $error("slot low length");
  a_slot_gap: assert property ($rose(line_oe) && $past(busy) |-> gap == 14'h2BC)
    else $error("slot spacing");
  a_byte_span: assert property ($fell(busy) && ^lop |-> blen >= 14'h15E0 && blen <= 14'h15E3)
    else $error("byte span");
  a_init_span: assert property ($fell(busy) && lop == 2'h0 |-> blen >= 14'h2580 && blen <= 14'h2583)
    else $error("init span");
  a_trip_span: assert property ($fell(busy) && &lop |-> (blen >= 14'h578 && blen <= 14'h57B)
    || (blen >= 14'h834 && blen <= 14'h837))
    else $error("triplet span");
  c_init: cover property (take && cmd_op == 2'h0);
  c_trip: cover property (take && cmd_op == 2'h3);
  c_full: cover property (rsp_valid && !rsp_ready && !busy && !cmd_ready);
endmodule
bind swi_host swi_host_sva i_sva
(
  .clk(clk), .reset(reset), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
  .cmd_data(cmd_data), .cmd_dir(cmd_dir), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready),
  .rsp_data(rsp_data), .rsp_flags(rsp_flags), .line_in(line_in), .line_out(line_out),
  .line_oe(line_oe), .busy(busy)
);

/* File: tb/tb.sv */
// bench: swi_host against one identity device on a pulled-up line
// assumes the checker binds itself to i_dut
`timescale 1ns/1ns
module tb;
  function [7:0] crc8(input [55:0] v);
    integer j;
    reg [7:0] c;
    begin
      c = 8'h00;
      for (j = 0; j < 56; j = j + 1)
        c = (c >> 1) ^ ((c[0] ^ v[j]) ? 8'h8C : 8'h00);
      crc8 = c;
    end
  endfunction
  // family and serial values are arbitrary
  localparam [55:0] ID_LO = {48'h3C71_9E02_B4D6, 8'h5A};
  localparam [63:0] ID    = {crc8(ID_LO), ID_LO};
  reg         clk, reset, cmd_valid, cmd_dir, rsp_ready, hold;
  reg  [1:0]  cmd_op;
  reg  [7:0]  cmd_data;
  reg  [31:0] expq[$];
  reg  [31:0] e;
  integer     seed, r, q, i, n_mismatch, compares;
  wire        cmd_ready, rsp_valid, line_out, line_oe, busy, pull, line;
  wire [7:0]  rsp_data, rsp_flags;
  assign line = (line_oe ? line_out : 1'b1) & ~pull;
  swi_host i_dut
  (
    .clk(clk), .reset(reset), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_op(cmd_op), .cmd_data(cmd_data), .cmd_dir(cmd_dir), .rsp_valid(rsp_valid),
    .rsp_ready(rsp_ready), .rsp_data(rsp_data), .rsp_flags(rsp_flags), .line_in(line),
    .line_out(line_out), .line_oe(line_oe), .busy(busy)
  );
  swi_dev_model #(.ID(ID)) i_dev (.line(line), .pull(pull));
  always #50 clk = ~clk;
  task check(input [15:0] seen, input [15:0] exp);
    begin
      compares = compares + 1;
      if (seen !== exp)
      begin
        n_mismatch = n_mismatch + 1;
        $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
    end
  endtask
  task give_verdict;
    begin
      $display("mismatches %0d compares %0d", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  // note the expectation, then hold the request until it is taken
  task do_cmd(input [1:0] op, input [7:0] d, input [15:0] ev, input [15:0] m);
    begin
      expq.push_back({m, ev & m});
      r = $random(seed);
      @(posedge clk);
      cmd_valid <= 1'b1;
      cmd_op <= op;
      cmd_data <= d;
      cmd_dir <= r[0];
      @(negedge clk);
      while (cmd_ready !== 1'b1)
        @(negedge clk);
      @(posedge clk);
      cmd_valid <= 1'b0;
    end
  endtask
  task do_init(input [7:0] c);
    begin
      do_cmd(2'h0, 8'h00, 16'h0001, 16'h0021);
      do_cmd(2'h1, c, {c, 8'h00}, 16'hFF00);
    end
  endtask
  task do_trip(input a, input b);
    do_cmd(2'h3, 8'h00, {11'h000, a, b, a, 2'h0}, 16'hFF3C);
  endtask
  // consumer stalls at random; each pop meets the oldest note
  always @(posedge clk)
  begin
    if (rsp_valid === 1'b1 && rsp_ready === 1'b1)
    begin
      e = expq.pop_front();
      check({rsp_data, rsp_flags} & e[31:16], e[15:0]);
    end
    q = $random(seed);
    rsp_ready <= !hold && q[1:0] != 2'h0;
  end
  initial
  begin
    seed = 32'h04D037B5;
    n_mismatch = 0;
    compares = 0;
    clk = 1'b0;
    reset = 1'b1;
    cmd_valid = 1'b0;
    cmd_op = 2'h0;
    cmd_data = 8'h00;
    cmd_dir = 1'b0;
    rsp_ready = 1'b0;
    hold = 1'b1;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    // two parked answers: a third command must wait
    do_init(8'h33);
    @(negedge clk);
    while (busy !== 1'b0)
      @(negedge clk);
    repeat (4) @(negedge clk);
    check({15'h0000, cmd_ready}, 16'h0000);
    check({15'h0000, rsp_valid}, 16'h0001);
    hold = 1'b0;
    for (i = 0; i < 8; i = i + 1)
      do_cmd(2'h2, 8'h00, {ID[8*i +: 8], 8'h02}, (i == 7) ? 16'hFF02 : 16'hFF00);
    // alternate read code: first two ID bits show as id and cmp bits
    do_init(8'h0F);
    do_trip(ID[0], ID[1]);
    // codes after which the device keeps off the line
    for (i = 0; i < 2; i = i + 1)
    begin
      do_init(i ? 8'hCC : 8'h55);
      do_cmd(2'h3, 8'h00, 16'h002C, 16'hFF2C);
    end
    do_init(8'hF0);
    do_trip(ID[0], ~ID[0]);
    do_trip(ID[1], ~ID[1]);
    @(negedge clk);
    while (expq.size() != 0)
      @(negedge clk);
    give_verdict;
  end
  // the sequence needs about 130k cycles
  initial
  begin
    #(100 * 160000);
    n_mismatch = n_mismatch + 1;
    give_verdict;
  end
endmodule
